// file: rtl/pcs_pkg.sv
// Purpose: Shared constants for the port control and status register group
// Assumes: APB word addressing, register index times four gives the byte address
// Notes:   Status inputs arrive synchronous to the core clock
package pcs_pkg;
    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [9:0] IDX_BASIC_CTRL = 10'h0e4;
    localparam logic [9:0] IDX_BASIC_STAT = 10'h0e6;
    localparam logic [9:0] IDX_ADVERT = 10'h0ec;
    localparam logic [9:0] IDX_SPECIAL = 10'h0f4;
    localparam logic [9:0] IDX_PORT_CTRL = 10'h0f6;
    localparam logic [9:0] IDX_PORT_STAT = 10'h0f8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SCL_START = 12;
    localparam int SCL_FORCE_LINK = 11;
    localparam int SCL_LOOPBACK = 9;
    localparam int PSR_SCHEME = 15;
    localparam int BC_LED_OFF = 0;
    localparam int BC_TX_DIS = 1;
    localparam int BC_XOVER_DIS = 3;
    localparam int BC_FORCE_MDI = 4;
    localparam int BC_SCHEME = 5;
    localparam int BC_FULL = 8;
    localparam int BC_RESTART = 9;
    localparam int BC_AN_EN = 12;
    localparam int BC_SPEED = 13;
    localparam int PCR_LED_OFF = 15;
    localparam int PCR_TX_DIS = 14;
    localparam int PCR_RESTART = 13;
    localparam int PCR_XOVER_DIS = 10;
    localparam int PCR_FORCE_MDI = 9;
    localparam int PCR_AN_EN = 7;
    localparam int PCR_SPEED = 6;
    localparam int PCR_FULL = 5;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [15:0] PCR_RST = 16'h00ff;
    localparam logic [15:0] PCR_WMASK = 16'he6ff;
    localparam logic [4:0] AN_SELECTOR = 5'h01;
    localparam logic [1:0] DIAG_FAILED = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int DIAG_TIMEOUT_US = 50;
    localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

    // Cable diagnostic sequencer states
    typedef enum logic [1:0] {
        DG_IDLE = 2'b00,
        DG_RUN = 2'b01
    } pcs_diag_state_t;
endpackage : pcs_pkg

// file: rtl/pcs_cable_diag.sv
// Purpose: Cable diagnostic sequencer, launches the front end and keeps its result
// Assumes: Front end pulses fe_done_i once per launched run
// Notes:   A run that never completes ends in the failed outcome
module pcs_cable_diag
    import pcs_pkg::*;
#(
    parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic fe_done_i,
    input wire logic [1:0] fe_result_i,
    input wire logic [8:0] fe_dist_i,
    output logic busy_o,
    output logic launch_o,
    output logic [1:0] result_o,
    output logic [8:0] dist_o
);
    pcs_diag_state_t state_reg, state_next;
    logic [15:0] tmo_reg, tmo_next;
    logic [1:0] result_reg, result_next;
    logic [8:0] dist_reg, dist_next;
    logic launch_reg;
    wire logic timed_out = (tmo_reg == 16'(TIMEOUT_CYC - 1));

    // ****************************************
    // Sequencer
    // ****************************************
    // Next state; starts while running are dropped
    always_comb begin
        state_next = state_reg;
        tmo_next = tmo_reg;
        result_next = result_reg;
        dist_next = dist_reg;
        case (state_reg)
            DG_IDLE: begin
                tmo_next = 16'h0000;
                if (start_i) begin
                    state_next = DG_RUN;
                end
            end
            DG_RUN: begin
                tmo_next = tmo_reg + 16'h0001;
                if (fe_done_i) begin
                    state_next = DG_IDLE;
                    result_next = fe_result_i;
                    dist_next = fe_dist_i;
                end else if (timed_out) begin
                    state_next = DG_IDLE;
                    result_next = DIAG_FAILED;
                    dist_next = 9'h000;
                end
            end
            default: begin
                state_next = DG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= DG_IDLE;
            tmo_reg <= 16'h0000;
            result_reg <= 2'h0;
            dist_reg <= 9'h000;
            launch_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmo_reg <= tmo_next;
            result_reg <= result_next;
            dist_reg <= dist_next;
            launch_reg <= (state_reg == DG_IDLE) && start_i;
        end
    end

    assign busy_o = (state_reg == DG_RUN);
    assign launch_o = launch_reg;
    assign result_o = result_reg;
    assign dist_o = dist_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_diag_capture;
        busy_o && fe_done_i |=> !busy_o && result_o == $past(fe_result_i)
            && dist_o == $past(fe_dist_i);
    endproperty
    a_diag_capture: assert property (p_diag_capture)
        else $error("diag result not captured");

    property p_diag_start;
        !busy_o && start_i |=> busy_o && launch_o ##1 !launch_o;
    endproperty
    a_diag_start: assert property (p_diag_start)
        else $error("diag run not launched");

    property p_diag_timeout;
        busy_o && timed_out && !fe_done_i |=> !busy_o && result_o == DIAG_FAILED;
    endproperty
    a_diag_timeout: assert property (p_diag_timeout)
        else $error("diag timeout not reported as failed");

    c_diag_done: cover property (busy_o ##1 !busy_o);
endmodule : pcs_cable_diag

// file: rtl/pcs_port_regs.sv
// Purpose: Port control and status registers for the copper port, on APB
// Assumes: Status inputs from the port core are synchronous to CLK_SYS_I
// Notes:   One wait state on every access; unmapped words answer with PSLVERR
//
// Chosen here: the APB register port.
module pcs_port_regs
    import pcs_pkg::*;
#(
    parameter int DIAG_TIMEOUT = DIAG_TIMEOUT_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic LINK_UP_I,
    input wire logic AN_DONE_I,
    input wire logic POL_REV_I,
    input wire logic RES_SPEED100_I,
    input wire logic RES_FULL_I,
    input wire logic MDI_STATE_I,
    input wire logic CABLE_DONE_I,
    input wire logic [1:0] CABLE_RESULT_I,
    input wire logic [8:0] CABLE_DIST_I,
    input wire logic [3:0] INDICATOR_I,
    output logic CABLE_START_O,
    output logic FORCE_LINK_O,
    output logic REMOTE_LOOPBACK_O,
    output logic [3:0] PORT_INDICATOR_O,
    output logic TX_DISABLE_O,
    output logic AN_RESTART_O,
    output logic AUTO_MDIX_EN_O,
    output logic FORCE_MDI_O,
    output logic AN_ENABLE_O,
    output logic FORCE_SPEED100_O,
    output logic FORCE_FULL_O,
    output logic [4:0] ADVERT_O,
    output logic XOVER_SCHEME_O,
    output logic LINK_GOOD_O
);
    // ****************************************
    // Helper functions
    // ****************************************
    // Byte-lane merge of a write into the current image
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] strb);
        merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // Port control storage seen through the basic control alias
    function automatic logic [15:0] pcr_to_bctl(input logic [15:0] p, input logic s);
        pcr_to_bctl = 16'h0000;
        pcr_to_bctl[BC_LED_OFF] = p[PCR_LED_OFF];
        pcr_to_bctl[BC_TX_DIS] = p[PCR_TX_DIS];
        pcr_to_bctl[BC_XOVER_DIS] = p[PCR_XOVER_DIS];
        pcr_to_bctl[BC_FORCE_MDI] = p[PCR_FORCE_MDI];
        pcr_to_bctl[BC_SCHEME] = s;
        pcr_to_bctl[BC_FULL] = p[PCR_FULL];
        pcr_to_bctl[BC_RESTART] = p[PCR_RESTART];
        pcr_to_bctl[BC_AN_EN] = p[PCR_AN_EN];
        pcr_to_bctl[BC_SPEED] = p[PCR_SPEED];
    endfunction : pcr_to_bctl

    // Basic control write folded back into port control storage
    function automatic logic [15:0] bctl_to_pcr(input logic [15:0] b, input logic [15:0] p);
        bctl_to_pcr = p;
        bctl_to_pcr[PCR_LED_OFF] = b[BC_LED_OFF];
        bctl_to_pcr[PCR_TX_DIS] = b[BC_TX_DIS];
        bctl_to_pcr[PCR_XOVER_DIS] = b[BC_XOVER_DIS];
        bctl_to_pcr[PCR_FORCE_MDI] = b[BC_FORCE_MDI];
        bctl_to_pcr[PCR_FULL] = b[BC_FULL];
        bctl_to_pcr[PCR_RESTART] = b[BC_RESTART];
        bctl_to_pcr[PCR_AN_EN] = b[BC_AN_EN];
        bctl_to_pcr[PCR_SPEED] = b[BC_SPEED];
    endfunction : bctl_to_pcr

    // ****************************************
    // State
    // ****************************************
    logic [15:0] pcr_reg, pcr_next;
    logic scheme_reg, scheme_next;
    logic force_link_reg, force_link_next;
    logic loopback_reg, loopback_next;
    logic restart_pulse_reg;
    logic xover_en_reg;
    logic [3:0] ind_reg;
    logic link_good_reg, an_done_reg, pol_reg;
    logic speed_st_reg, full_st_reg, mdi_st_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic diag_busy, diag_launch;
    logic [1:0] diag_result;
    logic [8:0] diag_dist;

    // ****************************************
    // APB decode
    // ****************************************
    // Index decode; misaligned byte addresses never match
    wire logic [9:0] idx = PADDR_I[11:2];
    wire logic aligned = (PADDR_I[1:0] == 2'b00);
    wire logic sel_bctl = aligned && (idx == IDX_BASIC_CTRL);
    wire logic sel_bstat = aligned && (idx == IDX_BASIC_STAT);
    wire logic sel_adv = aligned && (idx == IDX_ADVERT);
    wire logic sel_scl = aligned && (idx == IDX_SPECIAL);
    wire logic sel_pcr = aligned && (idx == IDX_PORT_CTRL);
    wire logic sel_psr = aligned && (idx == IDX_PORT_STAT);
    wire logic addr_ok = sel_bctl | sel_bstat | sel_adv | sel_scl | sel_pcr | sel_psr;
    // Sample point one cycle before the answer; completion on the answer edge
    wire logic acc_wait = PSEL_I && PENABLE_I && !pready_reg;
    wire logic acc_done = PSEL_I && PENABLE_I && pready_reg;
    wire logic wr_en = acc_done && PWRITE_I && addr_ok;

    // ****************************************
    // Read images
    // ****************************************
    // fault distance count
    wire logic [15:0] img_scl = {1'b0, diag_result, diag_busy, force_link_reg, 1'b0,
                                 loopback_reg, diag_dist};
    wire logic [15:0] img_pcr = pcr_reg & PCR_WMASK;
    wire logic [15:0] img_psr = {scheme_reg, 1'b0, pol_reg, 2'b00, speed_st_reg,
                                 full_st_reg, 1'b0, mdi_st_reg, an_done_reg,
                                 link_good_reg, 5'h00};
    wire logic [15:0] img_adv = {5'h00, pcr_reg[4], 1'b0, pcr_reg[3:0], AN_SELECTOR};
    wire logic [15:0] img_bctl = pcr_to_bctl(pcr_reg, scheme_reg);
    wire logic [15:0] img_bstat = {10'h000, an_done_reg, 2'b00, link_good_reg, 2'b00};
    wire logic [15:0] rd_img = sel_scl ? img_scl :
                               sel_pcr ? img_pcr :
                               sel_psr ? img_psr :
                               sel_adv ? img_adv :
                               sel_bctl ? img_bctl :
                               sel_bstat ? img_bstat : 16'h0000;
    wire logic [15:0] wv = merge16(rd_img, PWDATA_I[15:0], PSTRB_I[1:0]);

    // ****************************************
    // Write steering
    // ****************************************
    wire logic wr_scl = wr_en && sel_scl;
    wire logic wr_pcr = wr_en && sel_pcr;
    wire logic wr_psr = wr_en && sel_psr;
    wire logic wr_adv = wr_en && sel_adv;
    wire logic wr_bctl = wr_en && sel_bctl;
    wire logic diag_start = wr_scl && wv[SCL_START];
    wire logic [15:0] adv_fold = {pcr_reg[15:5], wv[10], wv[8:5]};
    assign pcr_next = wr_pcr ? (wv & PCR_WMASK) :
                      wr_bctl ? bctl_to_pcr(wv, pcr_reg) :
                      wr_adv ? adv_fold : pcr_reg;
    assign scheme_next = wr_psr ? wv[PSR_SCHEME] :
                         wr_bctl ? wv[BC_SCHEME] : scheme_reg;
    assign force_link_next = wr_scl ? wv[SCL_FORCE_LINK] : force_link_reg;
    assign loopback_next = wr_scl ? wv[SCL_LOOPBACK] : loopback_reg;
    // restart on a written one
    // Strobed data only, so a stored restart bit never re-fires on a low-byte write
    wire logic restart_wr = PSTRB_I[1] && ((wr_pcr && PWDATA_I[PCR_RESTART]) ||
                                           (wr_bctl && PWDATA_I[BC_RESTART]));

    // ****************************************
    // Register storage
    // ****************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pcr_reg <= PCR_RST;
            scheme_reg <= 1'b1;
            force_link_reg <= 1'b0;
            loopback_reg <= 1'b0;
            restart_pulse_reg <= 1'b0;
            xover_en_reg <= !PCR_RST[PCR_XOVER_DIS];
        end else begin
            pcr_reg <= pcr_next;
            scheme_reg <= scheme_next;
            force_link_reg <= force_link_next;
            loopback_reg <= loopback_next;
            restart_pulse_reg <= restart_wr;
            // Own flop fed from the next image: pin needs no inverter, no extra lag
            xover_en_reg <= !pcr_next[PCR_XOVER_DIS];
        end
    end

    // ****************************************
    // Status capture
    // ****************************************
    // Status sampled every cycle; forced values shown when negotiation is off
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            link_good_reg <= 1'b0;
            an_done_reg <= 1'b0;
            pol_reg <= 1'b0;
            speed_st_reg <= 1'b0;
            full_st_reg <= 1'b0;
            mdi_st_reg <= 1'b1;
            ind_reg <= 4'hf;
        end else begin
            link_good_reg <= LINK_UP_I || force_link_reg;
            an_done_reg <= AN_DONE_I;
            pol_reg <= POL_REV_I;
            speed_st_reg <= pcr_reg[PCR_AN_EN] ? RES_SPEED100_I : pcr_reg[PCR_SPEED];
            full_st_reg <= pcr_reg[PCR_AN_EN] ? RES_FULL_I : pcr_reg[PCR_FULL];
            mdi_st_reg <= MDI_STATE_I;
            ind_reg <= pcr_reg[PCR_LED_OFF] ? 4'hf : INDICATOR_I;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    // Fixed one wait state keeps read data stable for the answer edge
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc_wait;
            pslverr_reg <= acc_wait && !addr_ok;
            if (acc_wait && !PWRITE_I) begin
                prdata_reg <= {16'h0000, rd_img};
            end
        end
    end

    // ****************************************
    // Cable diagnostic
    // ****************************************
    pcs_cable_diag #(
        .TIMEOUT_CYC(DIAG_TIMEOUT)
    ) u_diag (
        .clk_i(CLK_SYS_I),
        .srst_i(SRST_I),
        .start_i(diag_start),
        .fe_done_i(CABLE_DONE_I),
        .fe_result_i(CABLE_RESULT_I),
        .fe_dist_i(CABLE_DIST_I),
        .busy_o(diag_busy),
        .launch_o(diag_launch),
        .result_o(diag_result),
        .dist_o(diag_dist)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign CABLE_START_O = diag_launch;
    assign FORCE_LINK_O = force_link_reg;
    assign REMOTE_LOOPBACK_O = loopback_reg;
    assign PORT_INDICATOR_O = ind_reg;
    assign TX_DISABLE_O = pcr_reg[PCR_TX_DIS];
    assign AN_RESTART_O = restart_pulse_reg;
    assign AUTO_MDIX_EN_O = xover_en_reg;
    assign FORCE_MDI_O = pcr_reg[PCR_FORCE_MDI];
    assign AN_ENABLE_O = pcr_reg[PCR_AN_EN];
    assign FORCE_SPEED100_O = pcr_reg[PCR_SPEED];
    assign FORCE_FULL_O = pcr_reg[PCR_FULL];
    assign ADVERT_O = pcr_reg[4:0];
    assign XOVER_SCHEME_O = scheme_reg;
    assign LINK_GOOD_O = link_good_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);

    property p_pready;
        acc_wait |=> PREADY_O ##1 !PREADY_O;
    endproperty
    a_pready: assert property (p_pready)
        else $error("apb answer not one wait state");

    property p_led_off;
        wr_pcr && wv[PCR_LED_OFF] |=> ##1 PORT_INDICATOR_O == 4'hf;
    endproperty
    a_led_off: assert property (p_led_off)
        else $error("indicators not blanked");

    property p_tx_dis;
        wr_pcr |=> TX_DISABLE_O == $past(wv[PCR_TX_DIS]);
    endproperty
    a_tx_dis: assert property (p_tx_dis)
        else $error("transmitter disable not applied");

    property p_restart;
        wr_pcr && PSTRB_I[1] && PWDATA_I[PCR_RESTART] |=> AN_RESTART_O ##1 !AN_RESTART_O
            || restart_wr;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart pulse missing");

    property p_xover;
        wr_pcr && wv[PCR_XOVER_DIS] && !wv[PCR_FORCE_MDI] |=> !AUTO_MDIX_EN_O && !FORCE_MDI_O;
    endproperty
    a_xover: assert property (p_xover)
        else $error("forced crossover mode wrong");

    property p_link;
        LINK_UP_I || FORCE_LINK_O |=> LINK_GOOD_O;
    endproperty
    a_link: assert property (p_link)
        else $error("link good not reported");

    property p_forced_speed;
        !AN_ENABLE_O && FORCE_SPEED100_O && !wr_en |=> speed_st_reg;
    endproperty
    a_forced_speed: assert property (p_forced_speed)
        else $error("forced speed not reported");

    property p_adv_alias;
        wr_adv && PSTRB_I[1] && PSTRB_I[0] |=> ADVERT_O == {$past(PWDATA_I[10]), $past(PWDATA_I[8:5])};
    endproperty
    a_adv_alias: assert property (p_adv_alias)
        else $error("advertisement alias not shared");

    property p_unmapped;
        acc_wait && !addr_ok |=> PSLVERR_O && PREADY_O;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    c_led_off: cover property (wr_pcr && wv[PCR_LED_OFF] ##2 PORT_INDICATOR_O == 4'hf);
    c_diag_run: cover property (diag_start ##[1:20] !diag_busy);
    c_bctl_write: cover property (wr_bctl);
    c_unmapped: cover property (PSLVERR_O);
endmodule : pcs_port_regs

// file: verif/pcs_fe_model.sv
// Purpose: Cable front end stand-in that answers a diagnostic launch
// Assumes: One launch at a time, delay of two cycles or more
// Notes:   Outcome lines scramble outside the answer pulse
module pcs_fe_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [9:0] delay_i,
    input wire logic [10:0] ans_i,
    output logic done_o = 1'b0,
    output logic [1:0] result_o = 2'h0,
    output logic [8:0] dist_o = 9'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // ****************
    // Answer timing
    // ****************
    // one done pulse per launch
    always @(posedge clk_i) begin
        done_o <= (cnt == 1) && !start_i;
        // Stale outcome never looks valid
        {result_o, dist_o} <= ((cnt == 1) && !start_i) ? ans_i : ~{result_o, dist_o};
        if (start_i) begin
            cnt <= delay_i;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : pcs_fe_model

// file: verif/pcs_port_regs_tb.sv
// Purpose: Self-checking bench for the port register group
// Assumes: APB master waits for PREADY_O, one request at a time
// Notes:   Random data from an LFSR seeded at 78; short diagnostic timeout
module pcs_port_regs_tb import pcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_SP = {IDX_SPECIAL, 2'b00};
    localparam logic [11:0] A_PC = {IDX_PORT_CTRL, 2'b00};
    localparam logic [11:0] A_PS = {IDX_PORT_STAT, 2'b00};
    localparam logic [11:0] A_AD = {IDX_ADVERT, 2'b00};
    localparam logic [11:0] A_BS = {IDX_BASIC_STAT, 2'b00};
    localparam logic [11:0] A_BC = {IDX_BASIC_CTRL, 2'b00};
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, err, xm = 1;
    logic link = 0, an_d = 0, pol = 0, sp = 0, fu = 0, mdi = 1;
    logic cdone, cst, fl, rlb, txd, anr, mx, fm, ane, fsp, ffu, xs, lg, pready, pslverr;
    logic [1:0] cres;
    logic [8:0] cdist;
    logic [3:0] pstrb = 4'hf, ind = 4'h0, ind_o;
    logic [4:0] adv;
    logic [9:0] fdly = 10'h008;
    logic [10:0] fans = 11'h000;
    logic [11:0] paddr = 12'h000;
    logic [15:0] lf = 16'h004e, pm = PCR_RST;
    logic [31:0] pwd = 32'h0, prd, rd, w;
    int fail_count = 0, num_checks = 0, cyc = 0;
    // ****************
    // Design and far side
    // ****************
    pcs_port_regs #(.DIAG_TIMEOUT(16)) dut_u (.CLK_SYS_I(clk), .SRST_I(srst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
        .PSTRB_I(pstrb), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .LINK_UP_I(link), .AN_DONE_I(an_d), .POL_REV_I(pol), .RES_SPEED100_I(sp),
        .RES_FULL_I(fu), .MDI_STATE_I(mdi), .CABLE_DONE_I(cdone), .CABLE_RESULT_I(cres),
        .CABLE_DIST_I(cdist), .INDICATOR_I(ind), .CABLE_START_O(cst), .FORCE_LINK_O(fl),
        .REMOTE_LOOPBACK_O(rlb), .PORT_INDICATOR_O(ind_o), .TX_DISABLE_O(txd),
        .AN_RESTART_O(anr), .AUTO_MDIX_EN_O(mx), .FORCE_MDI_O(fm), .AN_ENABLE_O(ane),
        .FORCE_SPEED100_O(fsp), .FORCE_FULL_O(ffu), .ADVERT_O(adv),
        .XOVER_SCHEME_O(xs), .LINK_GOOD_O(lg));
    pcs_fe_model fe_u (.clk_i(clk), .start_i(cst), .delay_i(fdly), .ans_i(fans),
        .done_o(cdone), .result_o(cres), .dist_o(cdist));
    always #2 clk = ~clk;
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Request held until PREADY_O is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwd <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prd;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        apb(0, A_PC, 32'h0, 4'h3);
        chk(rd, {16'h0, PCR_RST});
        apb(0, A_PS, 32'h0, 4'h3);
        chk(rd, 32'h8080);
        for (int i = 0; i < 40; i++) begin
            lf = nxt(lf);
            w = {~lf, nxt(lf)};
            apb(1, A_SP, {20'h0, lf[2], 1'b0, lf[1], 9'h1ff}, 4'h3);
            apb(1, A_PS, {16'h0, lf[3], 15'h7fff}, 4'h3);
            xm = lf[3];
            if (lf[4]) pm[7:0] = w[7:0];
            if (lf[5]) pm[15:8] = w[15:8];
            pm = pm & PCR_WMASK;
            apb(1, A_PC, w, {2'b11, lf[5:4]});
            {link, an_d, pol, sp, fu, mdi, ind} <= lf[15:6];
            #1 chk(anr, lf[5] & w[13]);
            apb(0, A_PC, 32'h0, 4'h3);
            chk(rd, pm);
            apb(0, A_AD, 32'h0, 4'h3);
            chk(rd, {21'h0, pm[4], 1'b0, pm[3:0], AN_SELECTOR});
            apb(0, A_SP, 32'h0, 4'h3);
            chk(rd, {20'h0, lf[2], 1'b0, lf[1], 9'h0});
            apb(0, A_PS, 32'h0, 4'h3);
            chk(rd, {16'h0, xm, 1'b0, pol, 2'b0, pm[7] ? sp : pm[6], pm[7] ? fu : pm[5],
                1'b0, mdi, an_d, link | lf[2], 5'h0});
            apb(0, A_BS, 32'h0, 4'h3);
            chk(rd, {26'h0, an_d, 2'b0, link | lf[2], 2'b0});
            chk({fl, rlb, xs, lg}, {lf[2], lf[1], xm, link | lf[2]});
            chk({ind_o, txd, mx, fm, ane, fsp, ffu, adv}, {pm[15] ? 4'hf : ind, pm[14],
                ~pm[10], pm[9], pm[7:0]});
        end
        // Writes through the basic control and advertisement aliases
        apb(1, A_BC, 32'h2019, 4'h3);
        apb(1, A_AD, 32'h0540, 4'h3);
        apb(0, A_PC, 32'h0, 4'h3);
        chk(rd, 32'h865a);
        apb(0, A_BC, 32'h0, 4'h3);
        chk(rd, 32'h2019);
        chk({xs, adv}, {1'b0, 5'h1a});
        // Each outcome code, then a run that never answers
        for (int k = 0; k < 5; k++) begin
            fans <= {k[1:0], lf[8:0]};
            fdly <= (k == 4) ? 10'h3ff : 10'(8 + 2 * k);
            apb(1, A_SP, 32'h1000, 4'h3);
            apb(0, A_SP, 32'h0, 4'h3);
            chk(rd[12], 32'h1);
            for (int n = 0; n < 40 && rd[12] !== 1'b0; n++) apb(0, A_SP, 32'h0, 4'h3);
            chk(rd, {17'h0, k == 4 ? DIAG_FAILED : k[1:0], 4'h0,
                k == 4 ? 9'h0 : lf[8:0]});
            lf = nxt(lf);
        end
        apb(0, 12'h3fc, 32'h0, 4'h3);
        chk({err, rd[30:0]}, 32'h8000_0000);
        summarize();
    end
endmodule : pcs_port_regs_tb
